// ===== inc/ddb_map.svh
`ifndef DDB_MAP_SVH
`define DDB_MAP_SVH

// data lane layout
`define DDB_LANE_W 9
`define DDB_LANES 2
// address width is small because the array is built from flip-flops
`define DDB_ADDR_W 4
// synchroniser depth on every pin input
`define DDB_SYNC_STAGES 2
// dll lock time in main_timing_pos cycles
`define DDB_LOCK_KCYC 2048
// clock period and power-up settle time
`define DDB_MCLK_NS 100
`define DDB_KINIT_NS 20000
`define DDB_KINIT_CYC ((`DDB_KINIT_NS + `DDB_MCLK_NS - 1) / `DDB_MCLK_NS)

`endif

// ===== inc/ddb_pkg.sv
`default_nettype none
package ddb_pkg;

  typedef enum logic [2:0] {
    DDB_CMD_DESEL = 3'h1,
    DDB_CMD_READ  = 3'h2,
    DDB_CMD_WRITE = 3'h4
  } ddb_cmd_t;

  typedef enum logic [2:0] {
    DDB_RO_IDLE  = 3'h1,
    DDB_RO_BEAT1 = 3'h2,
    DDB_RO_BEAT2 = 3'h4
  } ddb_rd_t;

  typedef enum logic [1:0] {
    DDB_WI_IDLE  = 2'h1,
    DDB_WI_BEAT2 = 2'h2
  } ddb_wr_t;

endpackage
`default_nettype wire

// ===== hdl/ddb_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module ddb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ddb_sync_t;

  ddb_sync_t s_q;
  ddb_sync_t s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d    = s_q;
    s_d.s1 = pinIn;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pinOut = s_q.s2;

endmodule
`default_nettype wire

// ===== hdl/ddb_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddb_map.svh"
module ddb_mem #(
  parameter int ADDR_W = `DDB_ADDR_W,
  parameter int LANE_W = `DDB_LANE_W,
  parameter int LANES  = `DDB_LANES
) (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          wrEn,
  input  wire logic [ADDR_W-1:0]             wrAddr,
  input  wire logic [2*LANES*LANE_W-1:0]     wrWord,
  input  wire logic [2*LANES-1:0]            wrMaskN,
  input  wire logic [ADDR_W-1:0]             rdAddr,
  output logic      [2*LANES*LANE_W-1:0]     rdWord
);

  localparam int ML     = 2 * LANES;
  localparam int WORD_W = ML * LANE_W;
  localparam int DEPTH  = 1 << ADDR_W;

  logic [DEPTH-1:0][WORD_W-1:0] memQ;
  logic [DEPTH-1:0][WORD_W-1:0] memD;

  // per-lane mask
  // a high mask bit keeps the stored lane untouched
  function automatic logic [WORD_W-1:0] mergeLanes(
    input logic [WORD_W-1:0] oldWord,
    input logic [WORD_W-1:0] newWord,
    input logic [ML-1:0]     maskN
  );
    logic [WORD_W-1:0] res;
    res = oldWord;
    for (int i = 0; i < ML; i++) begin
      if (!maskN[i]) begin
        res[i*LANE_W +: LANE_W] = newWord[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction

  always_comb begin
    memD = memQ;
    if (wrEn) begin
      memD[wrAddr] = mergeLanes(memQ[wrAddr], wrWord, wrMaskN);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      memQ <= '0;
    end else begin
      memQ <= memD;
    end
  end

  assign rdWord = memQ[rdAddr];

endmodule
`default_nettype wire

// ===== hdl/ddb_sram_port.sv
// How it works
// - Address, load_n and read_not_write are sampled at each main_timing_pos rise.
// - load_n low with read_not_write high starts a pipelined read.
// - Reads are pipelined; a new read may be accepted every cycle.
// - Each read or write command moves exactly two beats, pos edge then neg edge; a deselect moves none.
// - A new command may arrive on every main_timing_pos cycle.
// - Deselects travel through the same pipeline depth as reads.
// - A deselect after a read finishes both read beats before releasing the bus.
// - With load_n high, address and direction are ignored; a deselect is loaded and the address is held.
// - The bus goes idle only after all outstanding bursts complete.
// - Write beat two is taken at the following main_timing_neg rise.
// - Each write command forms one two-beat, double-width write.
// - Byte masks are sampled with their data beat.
// - A high byte_write_n lane leaves stored data unchanged.
// - Every 9-bit lane is masked independently in either beat.
// - The DLL is disabled while dll_disable_n is low.
// - Deselect or write leaves data drivers off for one cycle, two cycles later.
`timescale 1ns/1ps
`default_nettype none
`include "ddb_map.svh"
module ddb_sram_port
  import ddb_pkg::*;
#(
  parameter int ADDR_W    = `DDB_ADDR_W,
  parameter int LANE_W    = `DDB_LANE_W,
  parameter int LANES     = `DDB_LANES,
  parameter int LOCK_KCYC = `DDB_LOCK_KCYC,
  parameter int KINIT_CYC = `DDB_KINIT_CYC
) (
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic                      main_timing_pos,
  input  wire logic                      main_timing_neg,
  input  wire logic [ADDR_W-1:0]         sync_address_in,
  input  wire logic                      load_n,
  input  wire logic                      read_not_write,
  input  wire logic [LANES-1:0]          byte_write_n,
  input  wire logic [LANES*LANE_W-1:0]   dqIn,
  output logic      [LANES*LANE_W-1:0]   dqOut,
  output logic                           dqOe,
  input  wire logic                      dll_disable_n,
  output logic                           read_valid_out,
  output logic                           dllLocked,
  output logic                           clocksSettled
);

  localparam int DATA_W = LANES * LANE_W;
  localparam int SYNC_W = 5 + ADDR_W + LANES + DATA_W;
  localparam int LOCK_W = $clog2(LOCK_KCYC + 1);
  localparam int INIT_W = $clog2(KINIT_CYC + 1);

  typedef struct packed {
    logic                  kPrev;
    logic                  knPrev;
    ddb_cmd_t              st1Cmd;
    logic [ADDR_W-1:0]     st1Addr;
    ddb_cmd_t              st2Cmd;
    logic [ADDR_W-1:0]     st2Addr;
    ddb_rd_t               roPhase;
    logic [2*DATA_W-1:0]   rdWord;
    logic [DATA_W-1:0]     dqOut;
    logic                  dqOe;
    ddb_wr_t               wiPhase;
    logic [ADDR_W-1:0]     wrAddr;
    logic [DATA_W-1:0]     wrLow;
    logic [LANES-1:0]      wrLowMaskN;
    logic [LOCK_W-1:0]     lockCnt;
    logic                  dllLocked;
    logic [INIT_W-1:0]     initCnt;
    logic                  settled;
  } ddb_state_t;

  ddb_state_t s_q;
  ddb_state_t s_d;

  logic [SYNC_W-1:0]     pinSync;
  logic                  kSync;
  logic                  knSync;
  logic                  ldSync;
  logic                  rwSync;
  logic                  dllSync;
  logic [ADDR_W-1:0]     addrSync;
  logic [LANES-1:0]      bwSync;
  logic [DATA_W-1:0]     dqSync;
  logic                  kRise;
  logic                  knRise;
  logic                  memWrEn;
  logic [2*DATA_W-1:0]   memRdata;
  logic [DATA_W-1:0]     rdLow;
  logic [DATA_W-1:0]     wordHi;

  // every pin passes the same two stages, so relative timing is kept
  ddb_sync2 #(
    .W (SYNC_W)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pinIn  ({main_timing_pos, main_timing_neg, load_n, read_not_write,
              dll_disable_n, sync_address_in, byte_write_n, dqIn}),
    .pinOut (pinSync)
  );

  assign {kSync, knSync, ldSync, rwSync, dllSync, addrSync, bwSync, dqSync} = pinSync;
  assign kRise  = kSync & ~s_q.kPrev;
  assign knRise = knSync & ~s_q.knPrev;
  assign rdLow  = memRdata[DATA_W-1:0];
  assign wordHi = s_q.rdWord[2*DATA_W-1:DATA_W];

  function automatic ddb_cmd_t cmdDecode(input logic ldN, input logic rdNotWr);
    if (ldN) begin
      return DDB_CMD_DESEL;
    end
    return rdNotWr ? DDB_CMD_READ : DDB_CMD_WRITE;
  endfunction

  assign memWrEn = (s_q.wiPhase == DDB_WI_BEAT2) && knRise;

  // reads look up the array at output time, after earlier writes landed
  ddb_mem #(
    .ADDR_W (ADDR_W),
    .LANE_W (LANE_W),
    .LANES  (LANES)
  ) u_mem (
    .mclk    (mclk),
    .resetn  (resetn),
    .wrEn    (memWrEn),
    .wrAddr  (s_q.wrAddr),
    .wrWord  ({dqSync, s_q.wrLow}),
    .wrMaskN ({bwSync, s_q.wrLowMaskN}),
    .rdAddr  (s_q.st2Addr),
    .rdWord  (memRdata)
  );

  always_comb begin
    s_d        = s_q;
    s_d.kPrev  = kSync;
    s_d.knPrev = knSync;

    if (kRise) begin
      s_d.st2Cmd  = s_q.st1Cmd;
      s_d.st2Addr = s_q.st1Addr;
      // every edge loads; load_n high ignores inputs
      s_d.st1Cmd  = cmdDecode(ldSync, rwSync);
      s_d.st1Addr = ldSync ? s_q.st1Addr : addrSync;
    end

    // read output side; kRise wins, a late neg edge never stretches a burst
    case (s_q.roPhase)
      DDB_RO_IDLE, DDB_RO_BEAT2: begin
        if (kRise) begin
          if (s_q.st2Cmd == DDB_CMD_READ) begin
            s_d.rdWord  = memRdata;
            s_d.dqOut   = rdLow;
            s_d.dqOe    = 1'b1;
            s_d.roPhase = DDB_RO_BEAT1;
          end else begin
            s_d.dqOe    = 1'b0;
            s_d.roPhase = DDB_RO_IDLE;
          end
        end
      end
      DDB_RO_BEAT1: begin
        if (kRise) begin
          if (s_q.st2Cmd == DDB_CMD_READ) begin
            s_d.rdWord  = memRdata;
            s_d.dqOut   = rdLow;
            s_d.roPhase = DDB_RO_BEAT1;
          end else begin
            s_d.dqOe    = 1'b0;
            s_d.roPhase = DDB_RO_IDLE;
          end
        end else if (knRise) begin
          s_d.dqOut   = wordHi;
          s_d.roPhase = DDB_RO_BEAT2;
        end
      end
      default: begin
        s_d.dqOe    = 1'b0;
        s_d.roPhase = DDB_RO_IDLE;
      end
    endcase

    // write input side
    case (s_q.wiPhase)
      DDB_WI_IDLE, DDB_WI_BEAT2: begin
        if (kRise && s_q.st1Cmd == DDB_CMD_WRITE) begin
          s_d.wrAddr     = s_q.st1Addr;
          s_d.wrLow      = dqSync;
          s_d.wrLowMaskN = bwSync;
          s_d.wiPhase    = DDB_WI_BEAT2;
        end else if (knRise) begin
          s_d.wiPhase = DDB_WI_IDLE;
        end
      end
      default: begin
        s_d.wiPhase = DDB_WI_IDLE;
      end
    endcase

    if (!dllSync) begin
      s_d.lockCnt   = '0;
      s_d.dllLocked = 1'b0;
    end else if (kRise && !s_q.dllLocked) begin
      s_d.lockCnt = s_q.lockCnt + 1'b1;
      if (s_q.lockCnt == LOCK_W'(LOCK_KCYC - 1)) begin
        s_d.dllLocked = 1'b1;
      end
    end

    // power-up settle window, counted on mclk
    if (!s_q.settled) begin
      s_d.initCnt = s_q.initCnt + 1'b1;
      if (s_q.initCnt == INIT_W'(KINIT_CYC - 1)) begin
        s_d.settled = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q         <= '0;
      s_q.st1Cmd  <= DDB_CMD_DESEL;
      s_q.st2Cmd  <= DDB_CMD_DESEL;
      s_q.roPhase <= DDB_RO_IDLE;
      s_q.wiPhase <= DDB_WI_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign dqOut          = s_q.dqOut;
  assign dqOe           = s_q.dqOe;
  assign read_valid_out = s_q.dqOe;
  assign dllLocked      = s_q.dllLocked;
  assign clocksSettled  = s_q.settled;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_CMD_LOAD: assert property (
    kRise && !ldSync && rwSync |=> s_q.st1Cmd == DDB_CMD_READ
      && s_q.st1Addr == $past(addrSync))
    else $error("read command not loaded");

  AST_LD_IGNORE: assert property (
    kRise && ldSync |=> s_q.st1Cmd == DDB_CMD_DESEL && $stable(s_q.st1Addr))
    else $error("command loaded while load_n high");

  AST_BACK2BACK: assert property (
    kRise && !ldSync |=> s_q.st1Cmd != DDB_CMD_DESEL)
    else $error("back to back command dropped");

  AST_DESEL_DELAY: assert property (
    kRise && s_q.st1Cmd == DDB_CMD_DESEL |=> s_q.st2Cmd == DDB_CMD_DESEL)
    else $error("deselect not delayed like a read");

  AST_RD_START: assert property (
    kRise && s_q.st2Cmd == DDB_CMD_READ |=> s_q.dqOe
      && s_q.roPhase == DDB_RO_BEAT1 && s_q.dqOut == $past(rdLow))
    else $error("read beat one missing");

  AST_RD_BEAT2: assert property (
    s_q.roPhase == DDB_RO_BEAT1 && knRise && !kRise |=> s_q.dqOe
      && s_q.roPhase == DDB_RO_BEAT2 && s_q.dqOut == $past(wordHi))
    else $error("read beat two missing");

  AST_RELEASE: assert property (
    kRise && s_q.st2Cmd != DDB_CMD_READ |=> !s_q.dqOe ##1 !s_q.dqOe || kRise)
    else $error("drivers not released");

  AST_OE_HOLD: assert property (
    s_q.dqOe && !kRise |=> s_q.dqOe)
    else $error("read burst cut short");

  AST_WR_BEAT1: assert property (
    kRise && s_q.st1Cmd == DDB_CMD_WRITE |=> s_q.wiPhase == DDB_WI_BEAT2
      && s_q.wrLow == $past(dqSync) && s_q.wrLowMaskN == $past(bwSync))
    else $error("write beat one not captured");

  AST_WR_COMMIT: assert property (
    s_q.wiPhase == DDB_WI_BEAT2 && knRise && !kRise |-> memWrEn
      ##1 s_q.wiPhase == DDB_WI_IDLE)
    else $error("write beat two not committed");

  AST_DLL_OFF: assert property (
    !dllSync |=> !s_q.dllLocked && s_q.lockCnt == '0)
    else $error("dll not held off");

  COV_READ: cover property (s_q.roPhase == DDB_RO_BEAT1 ##[1:40] s_q.roPhase == DDB_RO_BEAT2);
  COV_WRITE: cover property (memWrEn);
  COV_RD_RD: cover property (s_q.roPhase == DDB_RO_BEAT2 && kRise && s_q.st2Cmd == DDB_CMD_READ);
  COV_RD_DESEL: cover property (s_q.dqOe ##1 !s_q.dqOe);

endmodule
`default_nettype wire

// ===== bench/ddb_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddb_ctl_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        reqLoadN,
  input  wire logic        reqRnw,
  input  wire logic [3:0]  reqAddr,
  input  wire logic [35:0] reqData,
  input  wire logic [3:0]  reqMaskN,
  output logic             kTick,
  output logic             main_timing_pos,
  output logic             main_timing_neg,
  output logic             load_n,
  output logic             read_not_write,
  output logic [3:0]       sync_address_in,
  output logic [1:0]       byte_write_n,
  output logic [17:0]      dqDrv
);
  logic [3:0]  ph;
  logic        due2;
  logic [35:0] curD;
  logic [3:0]  curM;
  logic [17:0] d2;
  logic [1:0]  m2;
  logic        isWr;
  // pins change mid-way between clock rises, three mclk clear of each rise
  assign kTick = (ph == 4'h8);
  assign isWr  = !load_n && !read_not_write;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ph              <= 4'h0;
      main_timing_pos <= 1'b0;
      main_timing_neg <= 1'b0;
      load_n          <= 1'b1;
      read_not_write  <= 1'b0;
      sync_address_in <= 4'h0;
      byte_write_n    <= 2'h3;
      dqDrv           <= 18'h0;
      due2            <= 1'b0;
    end else begin
      ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
      main_timing_pos <= (ph == 4'hb) || (ph < 4'h5);
      main_timing_neg <= (ph >= 4'h5) && (ph < 4'hb);
      if (kTick) begin
        load_n          <= reqLoadN;
        read_not_write  <= reqRnw;
        sync_address_in <= reqAddr;
        curD            <= reqData;
        curM            <= reqMaskN;
        due2            <= isWr;
        d2              <= curD[35:18];
        m2              <= curM[3:2];
        dqDrv           <= isWr ? curD[17:0] : ~dqDrv;
        byte_write_n    <= isWr ? curM[1:0] : 2'h3;
      end else if (ph == 4'h2) begin
        // released bus toggles so stale data can never pass for a match
        dqDrv           <= due2 ? d2 : ~dqDrv;
        byte_write_n    <= due2 ? m2 : 2'h3;
        due2            <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_ddb_sram_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_ddb_sram_port;
  logic        mclk;
  logic        resetn;
  logic        dll_disable_n;
  logic        reqLoadN;
  logic        reqRnw;
  logic [3:0]  reqAddr;
  logic [35:0] reqData;
  logic [3:0]  reqMaskN;
  logic        kTick;
  logic        main_timing_pos;
  logic        main_timing_neg;
  logic        load_n;
  logic        read_not_write;
  logic [3:0]  sync_address_in;
  logic [1:0]  byte_write_n;
  logic [17:0] dqDrv;
  logic [17:0] dqIn;
  logic [17:0] dqOut;
  logic        dqOe;
  logic        read_valid_out;
  logic        dllLocked;
  logic        clocksSettled;
  logic [35:0] mem [16];
  int          bad_count;
  int          n_checks;

  assign dqIn = dqOe ? dqOut : dqDrv;

  ddb_ctl_model ctl (
    .mclk(mclk), .resetn(resetn), .reqLoadN(reqLoadN), .reqRnw(reqRnw),
    .reqAddr(reqAddr), .reqData(reqData), .reqMaskN(reqMaskN), .kTick(kTick),
    .main_timing_pos(main_timing_pos), .main_timing_neg(main_timing_neg),
    .load_n(load_n), .read_not_write(read_not_write),
    .sync_address_in(sync_address_in), .byte_write_n(byte_write_n), .dqDrv(dqDrv)
  );

  ddb_sram_port #(.LOCK_KCYC(8), .KINIT_CYC(10)) DUT (
    .mclk(mclk), .resetn(resetn), .main_timing_pos(main_timing_pos),
    .main_timing_neg(main_timing_neg), .sync_address_in(sync_address_in),
    .load_n(load_n), .read_not_write(read_not_write), .byte_write_n(byte_write_n),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .dll_disable_n(dll_disable_n),
    .read_valid_out(read_valid_out), .dllLocked(dllLocked),
    .clocksSettled(clocksSettled)
  );

  always #50 mclk = ~mclk;

  task automatic chk(string what, logic [35:0] exp, logic [35:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask

  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] m);
    for (int i = 0; i < 4; i++)
      if (!m[i])
        o[9*i +: 9] = n[9*i +: 9];
    return o;
  endfunction

  // follows one command from its load edge to both beat slots two cycles on
  task automatic track(logic ln, logic rw, logic [3:0] a, logic [35:0] d, logic [3:0] m);
    logic [35:0] exp;
    logic        rd;
    rd = !ln && rw;
    repeat (22) @(posedge mclk);
    if (!ln && !rw)
      mem[a] = merge(mem[a], d, m);
    repeat (5) @(posedge mclk);
    exp = mem[a];
    tick(6);
    chk("enable one", {34'h0, rd, rd}, {34'h0, dqOe, read_valid_out});
    if (rd)
      chk("data one", {18'h0, exp[17:0]}, {18'h0, dqOut});
    tick(6);
    chk("enable two", {34'h0, rd, rd}, {34'h0, dqOe, read_valid_out});
    if (rd)
      chk("data two", {18'h0, exp[35:18]}, {18'h0, dqOut});
  endtask

  always @(posedge mclk)
    if (kTick === 1'b1)
      fork
        track(reqLoadN, reqRnw, reqAddr, reqData, reqMaskN);
      join_none

  task automatic issue(logic ln, logic rw, logic [3:0] a, logic [35:0] d, logic [3:0] m);
    int n;
    reqLoadN = ln;
    reqRnw   = rw;
    reqAddr  = a;
    reqData  = d;
    reqMaskN = m;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (kTick !== 1'b1 && n < 20);
    #5;
  endtask

  task automatic wr(logic [3:0] a, logic [35:0] d, logic [3:0] m);
    issue(1'b0, 1'b0, a, d, m);
  endtask

  task automatic rd(logic [3:0] a);
    issue(1'b0, 1'b1, a, 36'h0, 4'hf);
  endtask

  task automatic idle(int n);
    repeat (n) issue(1'b1, 1'b1, 4'ha, 36'h0, 4'hf);
  endtask

  task automatic sc_lock();
    tick(4);
    chk("settled early", 36'h0, {35'h0, clocksSettled});
    tick(12);
    chk("settled", 36'h1, {35'h0, clocksSettled});
    tick(120);
    chk("lock disabled", 36'h0, {35'h0, dllLocked});
    dll_disable_n = 1'b1;
    tick(48);
    chk("lock early", 36'h0, {35'h0, dllLocked});
    tick(84);
    chk("lock", 36'h1, {35'h0, dllLocked});
  endtask

  task automatic sc_rw();
    wr(4'h3, 36'h123456789, 4'h0);
    rd(4'h3);
    // read beats hold the shared wire until the next K rise is seen, so turn it round first
    idle(2);
    wr(4'h5, 36'hfedcba987, 4'h6);
    rd(4'h5);
    idle(2);
    wr(4'h5, 36'h0, 4'hf);
    rd(4'h5);
    idle(4);
  endtask

  task automatic sc_masks();
    for (int i = 0; i < 16; i++)
      wr(i[3:0], {4{i[3:0], 5'h15}}, i[3:0]);
    for (int i = 0; i < 16; i++)
      rd(i[3:0]);
    idle(4);
  endtask

  task automatic sc_desel();
    rd(4'h3);
    issue(1'b1, 1'b0, 4'h3, 36'h0, 4'h0);
    rd(4'h3);
    idle(2);
    rd(4'h3);
    rd(4'h5);
    idle(4);
  endtask

  initial begin
    mclk          = 1'b0;
    resetn        = 1'b0;
    dll_disable_n = 1'b0;
    reqLoadN      = 1'b1;
    reqRnw        = 1'b0;
    reqAddr       = 4'h0;
    reqData       = 36'h0;
    reqMaskN      = 4'hf;
    bad_count     = 0;
    n_checks      = 0;
    for (int i = 0; i < 16; i++)
      mem[i] = 36'h0;
    repeat (12) @(posedge mclk);
    #5;
    resetn = 1'b1;
    sc_lock();
    sc_rw();
    sc_masks();
    sc_desel();
    conclude();
  end

  initial begin
    // the sequence needs well under 2000 cycles
    #1000000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
